// ===== rtl/ccp_tb_params.svh
// Offsets, field positions, reset values and counts of the time-base control block.
// Assumes inclusion by bare name; definitions only.
`ifndef CCP_TB_PARAMS_SVH
`define CCP_TB_PARAMS_SVH

`define CCON1_ADDR        12'h000
`define CPERIOD_ADDR      12'h004
`define CSTATUS_ADDR      12'h008
`define CCON1_WMASK       32'h001FBF0F
`define CPERIOD_RST       16'hFFFF
`define COUNT_WRAP        16'hFFFF
`define ON_BIT            15
`define IDLE_STOP_BIT     13
`define SLEEP_RUN_BIT     12
`define RESYNC_BIT        11
`define CLKSEL_LSB        8
`define SYNC_LSB          16
`define SYNC_FREE         5'h1F
`define SYNC_NONE         5'h00
`define SYNC_SELF         5'h01
`define SYNC_PEER1        5'h02
`define SYNC_PEER3        5'h04
`define SYNC_EXTERNAL_INTERRUPT_PIN_ZERO         5'h09
`define SYNC_EXTERNAL_INTERRUPT_PIN_FOUR         5'h0D
`define SYNC_LC1          5'h10
`define SYNC_LC2          5'h11
`define SYNC_CMP1         5'h18
`define SYNC_CMP2         5'h19
`define SYNC_ADC          5'h1B
`define MODE_CAPTURE_MIN  4'h8

`endif

// ===== rtl/ccp_tb_pkg.sv
// Types shared by the time-base control block and its helpers.
// Assumes ccp_tb_params.svh is compiled alongside.
package ccp_tb_pkg;
  typedef enum logic [2:0] {
    clk_sys  = 3'h0,
    clk_ref  = 3'h1,
    clk_secondary_oscillator = 3'h2,
    clk_lc   = 3'h3,
    clk_pinb = 3'h6,
    clk_pina = 3'h7
  } clk_sel_t;

  typedef enum logic [1:0] {
    st_off  = 2'b00,
    st_run  = 2'b01,
    st_hold = 2'b11
  } run_state_t;
endpackage : ccp_tb_pkg

// ===== rtl/tick_if.sv
// Carries the edge-detected tick of a selected source between modules.
// Assumes one clock domain, core_clk.
interface tick_if;
  logic raw;
  logic tick;
  modport src (input raw, output tick);
  modport dst (output raw, input tick);
endinterface : tick_if

// ===== rtl/edge_sync.sv
// Two-flop synchroniser followed by a rising-edge detector.
// Assumes raw is asynchronous to core_clk.
module edge_sync (
  input  wire logic core_clk,
  input  wire logic rst,
  tick_if.src       port_s
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic tick;
  } es_state_t;

  es_state_t st_ff;
  es_state_t nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.meta = port_s.raw;
    nxt_st.sync = st_ff.meta;
    nxt_st.last = st_ff.sync;
    nxt_st.tick = st_ff.sync & ~st_ff.last;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign port_s.tick = st_ff.tick;
endmodule : edge_sync

// ===== rtl/sync_mux.sv
// Picks the sync event for the five-bit source code.
// Assumes all inputs are already single-cycle ticks on core_clk.
`include "ccp_tb_params.svh"
module sync_mux (
  input  wire logic [4:0] code,
  input  wire logic       self_evt,
  input  wire logic [2:0] peer_evt,
  input  wire logic [4:0] int_evt,
  input  wire logic [1:0] lc_evt,
  input  wire logic [1:0] cmp_evt,
  input  wire logic       adc_evt,
  output logic            evt
);
  always_comb begin
    evt = 1'b0;
    if (code == `SYNC_SELF) begin
      evt = self_evt;
    end else if (code >= `SYNC_PEER1 && code <= `SYNC_PEER3) begin
      evt = peer_evt[2'(code - `SYNC_PEER1)];
    end else if (code >= `SYNC_EXTERNAL_INTERRUPT_PIN_ZERO && code <= `SYNC_EXTERNAL_INTERRUPT_PIN_FOUR) begin
      evt = int_evt[3'(code - `SYNC_EXTERNAL_INTERRUPT_PIN_ZERO)];
    end else if (code == `SYNC_LC1) begin
      evt = lc_evt[0];
    end else if (code == `SYNC_LC2) begin
      evt = lc_evt[1];
    end else if (code == `SYNC_CMP1) begin
      evt = cmp_evt[0];
    end else if (code == `SYNC_CMP2) begin
      evt = cmp_evt[1];
    end else if (code == `SYNC_ADC) begin
      evt = adc_evt;
    end
  end
endmodule : sync_mux

// ===== rtl/ccp_time_base_control.sv
// Time-base control of a capture/compare/PWM module with an APB register port.
// Assumes a 20 MHz core_clk; clock pins and sync sources may be asynchronous.
//
// Register access over APB and the register offsets were decided locally.
`include "ccp_tb_params.svh"
module ccp_time_base_control (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        idle_mode,
  input  wire logic        sleep_mode,
  input  wire logic        reference_clock_output,
  input  wire logic        secondary_oscillator,
  input  wire logic        logic_cell_one,
  input  wire logic        time_base_clock_pin_a,
  input  wire logic        time_base_clock_pin_b,
  input  wire logic [2:0]  peer_sync,
  input  wire logic [4:0]  ext_int_pin,
  input  wire logic [1:0]  logic_cell_sync,
  input  wire logic [1:0]  comparator_sync,
  input  wire logic        adc_start,
  output logic [15:0]      time_base_count,
  output logic             period_event,
  output logic             module_active
);
  typedef struct packed {
    logic [31:0]             con1;
    logic [15:0]             period;
    logic [15:0]             count;
    ccp_tb_pkg::run_state_t  run;
    logic                    pevt;
    logic [31:0]             rdata;
    logic                    ready;
    logic                    err;
    logic                    resync_tick;
    logic                    mod_act;
  } top_state_t;

  top_state_t st_ff;
  top_state_t nxt_st;

  // External clock and sync sources each get a synchroniser and edge detector.
  localparam int N_SRC = 18;
  logic [N_SRC-1:0] src_raw;
  logic [N_SRC-1:0] src_tick;

  assign src_raw = {adc_start, comparator_sync, logic_cell_sync, ext_int_pin, peer_sync,
                    time_base_clock_pin_a, time_base_clock_pin_b, logic_cell_one,
                    secondary_oscillator, reference_clock_output};

  genvar gi;
  generate
    for (gi = 0; gi < N_SRC; gi++) begin : g_src
      tick_if t_if ();
      assign t_if.raw      = src_raw[gi];
      assign src_tick[gi]  = t_if.tick;
      edge_sync u_es (
        .core_clk (core_clk),
        .rst      (rst),
        .port_s   (t_if.src)
      );
    end
  endgenerate

  logic       sync_evt;
  logic [4:0] sync_code;
  assign sync_code = st_ff.con1[`SYNC_LSB +: 5];

  sync_mux u_mux (
    .code     (sync_code),
    .self_evt (st_ff.pevt),
    .peer_evt (src_tick[7:5]),
    .int_evt  (src_tick[12:8]),
    .lc_evt   (src_tick[14:13]),
    .cmp_evt  (src_tick[16:15]),
    .adc_evt  (src_tick[N_SRC-1]),
    .evt      (sync_evt)
  );

  logic                   apb_wr;
  logic                   apb_rd;
  logic                   sel_con1;
  logic                   sel_per;
  logic                   sel_stat;
  logic                   cap_mode;
  logic                   enabled;
  logic                   halted;
  logic                   clk_tick;
  logic                   raw_tick;
  logic                   wrap_hit;
  logic [31:0]            wmask;
  ccp_tb_pkg::clk_sel_t   csel;

  always_comb begin
    apb_wr   = psel & penable & pwrite & ~st_ff.ready;
    apb_rd   = psel & penable & ~pwrite & ~st_ff.ready;
    sel_con1 = (paddr == `CCON1_ADDR);
    sel_per  = (paddr == `CPERIOD_ADDR);
    sel_stat = (paddr == `CSTATUS_ADDR);
    wmask    = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    // Capture modes own the time base themselves, so enable is ignored there.
    cap_mode = (st_ff.con1[3:0] >= `MODE_CAPTURE_MIN);
    enabled  = st_ff.con1[`ON_BIT] & ~cap_mode;
    halted   = (idle_mode & st_ff.con1[`IDLE_STOP_BIT])
             | (sleep_mode & ~st_ff.con1[`SLEEP_RUN_BIT]);
    csel     = ccp_tb_pkg::clk_sel_t'(st_ff.con1[`CLKSEL_LSB +: 3]);
    case (csel)
      ccp_tb_pkg::clk_sys:  raw_tick = 1'b1;
      ccp_tb_pkg::clk_ref:  raw_tick = src_tick[0];
      ccp_tb_pkg::clk_secondary_oscillator: raw_tick = src_tick[1];
      ccp_tb_pkg::clk_lc:   raw_tick = src_tick[2];
      ccp_tb_pkg::clk_pinb: raw_tick = src_tick[3];
      ccp_tb_pkg::clk_pina: raw_tick = src_tick[4];
      default:              raw_tick = 1'b0;
    endcase
    // Resync retimes an external tick through one more system-clock flop:
    // no edge is lost, the cost being one cycle of latency.
    if (st_ff.con1[`RESYNC_BIT] && csel != ccp_tb_pkg::clk_sys) begin
      clk_tick = st_ff.resync_tick;
    end else begin
      clk_tick = raw_tick;
    end
    if (sync_code == `SYNC_FREE) begin
      wrap_hit = (st_ff.count == `COUNT_WRAP);
    end else begin
      wrap_hit = (st_ff.count == `COUNT_WRAP) || (st_ff.count == st_ff.period);
    end
  end

  always_comb begin
    nxt_st         = st_ff;
    nxt_st.pevt    = 1'b0;
    nxt_st.ready   = 1'b0;
    nxt_st.err     = 1'b0;
    nxt_st.resync_tick = raw_tick;

    case (st_ff.run)
      ccp_tb_pkg::st_off: begin
        nxt_st.count = 16'h0000;
        if (enabled) begin
          nxt_st.run = ccp_tb_pkg::st_run;
        end
      end
      ccp_tb_pkg::st_run: begin
        if (!enabled) begin
          nxt_st.run = ccp_tb_pkg::st_off;
        end else if (halted) begin
          nxt_st.run = ccp_tb_pkg::st_hold;
        end else if (sync_evt && sync_code != `SYNC_FREE) begin
          nxt_st.count = 16'h0000;
        end else if (clk_tick) begin
          if (wrap_hit) begin
            nxt_st.count = 16'h0000;
            nxt_st.pevt  = 1'b1;
          end else begin
            nxt_st.count = 16'(st_ff.count + 16'h0001);
          end
        end
      end
      ccp_tb_pkg::st_hold: begin
        if (!enabled) begin
          nxt_st.run = ccp_tb_pkg::st_off;
        end else if (!halted) begin
          nxt_st.run = ccp_tb_pkg::st_run;
        end
      end
      default: nxt_st.run = ccp_tb_pkg::st_off;
    endcase
    nxt_st.mod_act = (nxt_st.run == ccp_tb_pkg::st_run);

    if (apb_wr || apb_rd) begin
      nxt_st.ready = 1'b1;
      nxt_st.rdata = 32'h0000_0000;
      if (sel_con1) begin
        if (apb_wr) begin
          nxt_st.con1 = (st_ff.con1 & ~(wmask & `CCON1_WMASK)) | (pwdata & wmask & `CCON1_WMASK);
        end
        nxt_st.rdata = st_ff.con1;
      end else if (sel_per) begin
        if (apb_wr) begin
          if (pstrb[0]) nxt_st.period[7:0]  = pwdata[7:0];
          if (pstrb[1]) nxt_st.period[15:8] = pwdata[15:8];
        end
        nxt_st.rdata = {16'h0000, st_ff.period};
      end else if (sel_stat) begin
        nxt_st.err   = apb_wr;
        nxt_st.rdata = {13'h0000, st_ff.mod_act, st_ff.run, st_ff.count};
      end else begin
        nxt_st.err = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_ff        <= '0;
      st_ff.period <= `CPERIOD_RST;
      st_ff.run    <= ccp_tb_pkg::st_off;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata          = st_ff.rdata;
  assign pready          = st_ff.ready;
  assign pslverr         = st_ff.err;
  assign time_base_count = st_ff.count;
  assign period_event    = st_ff.pevt;
  assign module_active   = st_ff.mod_act;
endmodule : ccp_time_base_control

// ===== tb/ccp_partner.sv
// Far-side sources: sync strobes on command and free-running clock sources.
// Assumes the bench holds each strobe long enough for a 2-flop synchroniser.
module ccp_partner (
  input  wire logic        core_clk,
  input  wire logic [12:0] fire,
  output logic [12:0]      src,
  output logic [5:0]       osc
);
  timeunit 1ns;
  timeprecision 1ns;
  // Oscillators run free, so each clock input is one counter bit of its own rate
  logic [5:0] cnt_ff = 6'h00;
  always_ff @(posedge core_clk) cnt_ff <= cnt_ff + 6'h01;
  assign osc = cnt_ff;
  assign src = fire;
endmodule // ccp_partner

// ===== tb/ccp_time_base_control_sva.sv
// Checker of the time-base control block, bound to its top ports.
// Assumes the control register is written only with all byte lanes on.
`include "ccp_tb_params.svh"
module ccp_time_base_control_sva (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        idle_mode,
  input wire logic        sleep_mode,
  input wire logic [15:0] time_base_count,
  input wire logic        period_event,
  input wire logic        module_active
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] ctl_ff;
  always_ff @(posedge core_clk)
    if (rst) ctl_ff <= 32'h00000000;
    // Mirrors the edge at which the block commits a write, one before pready
    else if (psel && penable && !pready && pwrite && paddr == 12'h000)
      ctl_ff <= pwdata & `CCON1_WMASK;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_ready; psel && penable && !pready |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready not one cycle after access");
  property p_refuse;
    pready && (!(paddr inside {12'h000, 12'h004, 12'h008}) || pwrite && paddr == 12'h008)
      |-> pslverr && (pwrite || prdata == 32'h00000000);
  endproperty
  a_refuse: assert property (p_refuse) else $error("bad access not refused");
  property p_wrap;
    $past(time_base_count) == 16'hFFFF && time_base_count == 16'h0000 |-> period_event;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap without period event");
  property p_step; $changed(time_base_count) |->
    time_base_count == $past(time_base_count) + 16'h0001 || time_base_count == 16'h0000;
  endproperty
  a_step: assert property (p_step) else $error("count jumped");
  property p_idle; (ctl_ff[13] && idle_mode) [*3] |=> $stable(time_base_count); endproperty
  a_idle: assert property (p_idle) else $error("count moved in idle");
  property p_sleep; (!ctl_ff[12] && sleep_mode) [*3] |=> $stable(time_base_count); endproperty
  a_sleep: assert property (p_sleep) else $error("count moved in sleep");
  property p_cap; ctl_ff[3:0] >= 4'h8 && !module_active |=> !module_active; endproperty
  a_cap: assert property (p_cap) else $error("capture mode ran");
  property p_en; !ctl_ff[15] [*3] |-> !module_active; endproperty
  a_en: assert property (p_en) else $error("active while disabled");
  property p_rsvclk;
    (ctl_ff[10:9] == 2'b10 && ctl_ff[20:16] == 5'h00) [*5] |=> $stable(time_base_count);
  endproperty
  a_rsvclk: assert property (p_rsvclk) else $error("reserved clock ticked");
endmodule // ccp_time_base_control_sva
bind ccp_time_base_control ccp_time_base_control_sva sva_i (.core_clk, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .idle_mode, .sleep_mode,
  .time_base_count, .period_event, .module_active);

// ===== tb/ccp_time_base_control_bench.sv
// Self-checking bench of the time-base control block over APB.
// Assumes a 1-cycle-late pready and period reset FFFF.
module ccp_time_base_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic idle_mode = 1'b0, sleep_mode = 1'b0, pready, pslverr, period_event, module_active;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, rv;
  logic [12:0] fire = 13'h0000, src;
  logic [5:0]  osc;
  logic [15:0] time_base_count, c0;
  logic        re;
  int          error_cnt = 0, n_tests = 0, n;
  typedef struct { logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic er; } row_t;
  row_t rows [8] = '{'{1'b0, 12'h000, 32'h0, 32'h00000000, 1'b0},
    '{1'b0, 12'h004, 32'h0, 32'h0000FFFF, 1'b0}, '{1'b1, 12'h004, 32'hABCD1234, 32'h0, 1'b0},
    '{1'b0, 12'h004, 32'h0, 32'h00001234, 1'b0}, '{1'b1, 12'h000, 32'hFFFFFFFF, 32'h0, 1'b0},
    '{1'b0, 12'h000, 32'h0, 32'h001FBF0F, 1'b0}, '{1'b1, 12'h008, 32'h5, 32'h0, 1'b1},
    '{1'b0, 12'h00C, 32'h0, 32'h00000000, 1'b1}};
  logic [4:0] codes [14] = '{5'h02, 5'h03, 5'h04, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D,
    5'h10, 5'h11, 5'h18, 5'h19, 5'h1B, 5'h05};
  // Clock rows: control low half, then bounds of ticks in 256 cycles
  logic [15:0] ck [9] = '{16'h8001, 16'h8101, 16'h8201, 16'h8301, 16'h8401, 16'h8501,
    16'h8601, 16'h8701, 16'h8E01};
  int lo [9] = '{255, 31, 15, 7, 0, 0, 63, 3, 63};
  int hi [9] = '{257, 33, 17, 9, 0, 0, 65, 5, 65};
  always #25 core_clk = ~core_clk;
  ccp_partner fs (.core_clk(core_clk), .fire(fire), .src(src), .osc(osc));
  ccp_time_base_control dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode), .sleep_mode(sleep_mode),
    .reference_clock_output(osc[2]), .secondary_oscillator(osc[3]),
    .logic_cell_one(osc[4]), .time_base_clock_pin_a(osc[5]), .time_base_clock_pin_b(osc[1]),
    .peer_sync(src[2:0]), .ext_int_pin(src[7:3]), .logic_cell_sync(src[9:8]),
    .comparator_sync(src[11:10]), .adc_start(src[12]), .time_base_count(time_base_count),
    .period_event(period_event), .module_active(module_active));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic rng(input string nm, input logic [31:0] l, input logic [31:0] h,
                     input logic [31:0] s);
    n_tests++;
    if ((s >= l && s <= h) !== 1'b1) begin
      error_cnt++;
      $display("ERROR %s expected %0h..%0h seen %0h", nm, l, h, s);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // Request held until pready is sampled high; the wait is bounded
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge core_clk); k++; end while (pready !== 1'b1 && k < 20);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    rng("pready wait", 0, 19, k);
  endtask
  task automatic wait_ev(output int k);
    k = 0;
    do begin @(posedge core_clk); k++; end while (period_event !== 1'b1 && k < 70000);
  endtask
  initial begin
    #(50 * 90000);
    error_cnt++;
    end_of_test();
  end
  initial begin
    cyc(5);
    rst <= 1'b0;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      rng("pslverr", rows[i].er, rows[i].er, re);
      if (!rows[i].w) rng("prdata", rows[i].e, rows[i].e, rv);
    end
    rng("active in capture", 0, 0, module_active);
    $display("register rows done");
    apb(1'b1, 12'h004, 32'h10);
    apb(1'b1, 12'h000, 32'h8001);
    wait_ev(n);
    wait_ev(n);
    rng("period gap", 17, 17, n);
    // Own-event sync clears the count once more after each wrap
    apb(1'b1, 12'h000, 32'h00018001);
    wait_ev(n);
    wait_ev(n);
    rng("self sync gap", 18, 18, n);
    apb(1'b1, 12'h000, 32'h001F8001);
    cyc(40);
    rng("free past period", 16'h0011, 16'hFFFF, time_base_count);
    wait_ev(n);
    rng("free wrap", 0, 69999, n);
    $display("period tests done");
    apb(1'b1, 12'h004, 32'hFFFF);
    foreach (codes[i]) begin
      apb(1'b1, 12'h000, {11'h0, codes[i], 16'h8001});
      cyc(30);
      fire <= (i == 13) ? 13'h1FFF : 13'h0001 << i;
      cyc(4);
      fire <= 13'h0000;
      cyc(3);
      if (i == 13) rng("reserved sync", 30, 16'hFFFF, time_base_count);
      else rng("sync restart", 0, 8, time_base_count);
    end
    $display("sync tests done");
    foreach (ck[i]) begin
      apb(1'b1, 12'h000, {16'h0, ck[i]});
      cyc(8);
      c0 = time_base_count;
      cyc(256);
      rng("clock ticks", lo[i], hi[i], 16'(time_base_count - c0));
    end
    $display("clock tests done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'h000, (i == 0) ? 32'hA001 : (i == 3) ? 32'h9001 : 32'h8001);
      idle_mode <= (i < 2);
      sleep_mode <= (i >= 2);
      cyc(5);
      c0 = time_base_count;
      cyc(20);
      n = (i == 1 || i == 3) ? 20 : 0;
      rng("power mode ticks", n, n, 16'(time_base_count - c0));
      idle_mode <= 1'b0;
      sleep_mode <= 1'b0;
    end
    $display("power tests done");
    apb(1'b1, 12'h000, 32'h0001);
    cyc(3);
    rng("active off", 0, 0, module_active);
    apb(1'b1, 12'h000, 32'h8001);
    cyc(3);
    rng("active on", 1, 1, module_active);
    rst <= 1'b1;
    cyc(5);
    rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    rng("ctl after reset", 0, 0, rv);
    rng("count after reset", 0, 1, time_base_count);
    $display("enable and reset tests done");
    end_of_test();
  end
endmodule // ccp_time_base_control_bench
